// ===== dgp_board.sv
// board model: resolves port pin levels from device drive, board drive and pull-ups
`timescale 1ns/1ps
`default_nettype none
module dgp_board (
    input  wire logic       clock,
    input  wire logic [5:0] a_out,
    input  wire logic [5:0] a_oe,
    input  wire logic [5:0] a_drv,
    input  wire logic [5:0] a_en,
    input  wire logic [7:0] b_out,
    input  wire logic [7:0] b_oe,
    input  wire logic [7:0] b_pull,
    input  wire logic [7:0] b_drv,
    input  wire logic [7:0] b_en,
    output logic      [5:0] a_pin,
    output logic      [7:0] b_pin
);
    logic [5:0] a_last_q = '0;
    logic [7:0] b_last_q = '0;
    // released line without pull-up toggles, never holds a stale level
    always_comb begin
        a_pin = (a_oe & a_out) | (~a_oe & a_en & a_drv) | (~a_oe & ~a_en & ~a_last_q);
        b_pin = (b_oe & b_out) | (~b_oe & b_en & b_drv) | (~b_oe & ~b_en & b_pull)
              | (~b_oe & ~b_en & ~b_pull & ~b_last_q);
    end
    always_ff @(posedge clock) begin
        a_last_q <= a_pin;
        b_last_q <= b_pin;
    end
endmodule
`default_nettype wire

// ===== dgp_pkg.sv
// constants, register map and state record of the dual general-purpose port
package dgp_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PA_W   = 6;
    localparam int unsigned PB_W   = 8;

    localparam logic [7:0] OFS_PA_DATA = 8'h05;
    localparam logic [7:0] OFS_PA_DIR  = 8'h85;
    localparam logic [7:0] OFS_ACFG    = 8'h9F;
    localparam logic [7:0] OFS_PB_DATA = 8'h06;
    localparam logic [7:0] OFS_PB_DIR  = 8'h86;
    localparam logic [7:0] OFS_OPTION  = 8'h81;
    localparam logic [7:0] OFS_INTCTL  = 8'h0B;
    localparam logic [7:0] OFS_PA_BMOD = 8'h45;
    localparam logic [7:0] OFS_PB_BMOD = 8'h46;

    localparam int unsigned OPT_PULLUP_DIS_N_BIT = 7;
    localparam int unsigned OPT_EDGE_SEL_BIT     = 6;
    localparam int unsigned INT_PIN_CHANGE_BIT   = 0;
    localparam int unsigned INT_EXT_FLAG_BIT     = 1;
    localparam int unsigned PA_T0CK_BIT          = 4;
    localparam int unsigned PA_SS_BIT            = 5;
    localparam int unsigned PB_EXT_INT_BIT       = 0;

    localparam logic [5:0] PA_DIR_RST  = 6'h3F;
    localparam logic [7:0] PB_DIR_RST  = 8'hFF;
    localparam logic [2:0] ACFG_RST    = 3'h0;
    localparam logic       PULLUP_N_RST = 1'b1;
    localparam logic       EDGE_SEL_RST = 1'b1;
    localparam logic [5:0] PA_PUSH_PULL = 6'h2F;

    typedef struct packed {
        logic [5:0] pa_lat;
        logic [5:0] pa_dir;
        logic [2:0] acfg;
        logic [7:0] pb_lat;
        logic [7:0] pb_dir;
        logic       pullup_disable_n;
        logic       ext_int_edge_select;
        logic [3:0] pb_snap;
        logic       pin_change_flag;
        logic       ext_int_flag;
        logic       pb0_prev;
        logic       edge_armed;
        logic [7:0] rdata;
        logic [5:0] pa_out;
        logic [5:0] pa_oe;
        logic [7:0] pb_out;
        logic [7:0] pb_oe;
        logic [7:0] pb_pullup;
        logic       wake;
        logic       t0ck;
        logic       ss_n;
    } dgp_state_s;

    localparam dgp_state_s STATE_RST = '{
        pa_dir:              PA_DIR_RST,
        pb_dir:              PB_DIR_RST,
        acfg:                ACFG_RST,
        pullup_disable_n:    PULLUP_N_RST,
        ext_int_edge_select: EDGE_SEL_RST,
        ss_n:                1'b1,
        default:             '0
    };

endpackage

// ===== dgp_port.sv
// dual general-purpose port with pin-change detect and external interrupt edge
`timescale 1ns/1ps
`default_nettype none
module dgp_port (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic [5:0] first_io_port_in,
    output logic      [5:0] first_io_port_out,
    output logic      [5:0] first_io_port_oe,
    input  wire logic [7:0] second_io_port_in,
    output logic      [7:0] second_io_port_out,
    output logic      [7:0] second_io_port_oe,
    output logic      [7:0] second_port_pullup_en,
    input  wire logic       timer0_ext_enable,
    input  wire logic       sync_serial_port_enable,
    output logic            timer0_ext_clock_in,
    output logic            sync_serial_port_ss_n,
    output logic            pin_change_flag,
    output logic            ext_int_flag,
    output logic            wake
);

    dgp_pkg::dgp_state_s s_q;
    dgp_pkg::dgp_state_s s_d;

    logic [5:0] pa_dig;
    logic [7:0] pa_bmod;
    logic [3:0] pb_mism;
    logic       ext_hit;

    // analog pins per configuration code; unlisted codes make all pins digital
    function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
        logic [5:0] m;
        m = 6'h00;
        case (cfg)
            3'h0: m = 6'h2F;
            3'h1: m = 6'h0F;
            3'h2: m = 6'h07;
            3'h3: m = 6'h03;
            3'h4: m = 6'h01;
            default: m = 6'h00;
        endcase
        return m;
    endfunction

    // replace bit cmd[2:0] of the sampled pin value with cmd[7]
    function automatic logic [7:0] bit_modify(input logic [7:0] cur, input logic [7:0] cmd);
        logic [7:0] v;
        v = cur;
        v[cmd[2:0]] = cmd[7];
        return v;
    endfunction

    always_comb begin
        s_d = s_q;
        pa_dig = first_io_port_in & ~analog_mask(s_q.acfg);
        pa_bmod = bit_modify({2'h0, pa_dig}, wdata);
        pb_mism = (second_io_port_in[7:4] ^ s_q.pb_snap) & s_q.pb_dir[7:4];
        // no edge against the reset value of the previous sample
        if (s_q.ext_int_edge_select) begin
            ext_hit = s_q.edge_armed & second_io_port_in[dgp_pkg::PB_EXT_INT_BIT]
                      & ~s_q.pb0_prev;
        end else begin
            ext_hit = s_q.edge_armed & ~second_io_port_in[dgp_pkg::PB_EXT_INT_BIT]
                      & s_q.pb0_prev;
        end
        s_d.pb0_prev = second_io_port_in[dgp_pkg::PB_EXT_INT_BIT];
        s_d.edge_armed = 1'b1;
        s_d.rdata = 8'h00;

        if (rd) begin
            if (addr == dgp_pkg::OFS_PA_DATA) begin
                s_d.rdata = {2'h0, pa_dig};
            end else if (addr == dgp_pkg::OFS_PA_DIR) begin
                s_d.rdata = {2'h0, s_q.pa_dir};
            end else if (addr == dgp_pkg::OFS_ACFG) begin
                s_d.rdata = {5'h00, s_q.acfg};
            end else if (addr == dgp_pkg::OFS_PB_DATA) begin
                s_d.rdata = second_io_port_in;
                s_d.pb_snap = second_io_port_in[7:4];
            end else if (addr == dgp_pkg::OFS_PB_DIR) begin
                s_d.rdata = s_q.pb_dir;
            end else if (addr == dgp_pkg::OFS_OPTION) begin
                s_d.rdata = {s_q.pullup_disable_n, s_q.ext_int_edge_select, 6'h00};
            end else if (addr == dgp_pkg::OFS_INTCTL) begin
                s_d.rdata = {6'h00, s_q.ext_int_flag, s_q.pin_change_flag};
            end
        end

        if (wr) begin
            if (addr == dgp_pkg::OFS_PA_DATA) begin
                s_d.pa_lat = wdata[5:0];
            end else if (addr == dgp_pkg::OFS_PA_BMOD) begin
                s_d.pa_lat = pa_bmod[5:0];
            end else if (addr == dgp_pkg::OFS_PA_DIR) begin
                s_d.pa_dir = wdata[5:0];
            end else if (addr == dgp_pkg::OFS_ACFG) begin
                s_d.acfg = wdata[2:0];
            end else if (addr == dgp_pkg::OFS_PB_DATA) begin
                s_d.pb_lat = wdata;
                s_d.pb_snap = second_io_port_in[7:4];
            end else if (addr == dgp_pkg::OFS_PB_BMOD) begin
                s_d.pb_lat = bit_modify(second_io_port_in, wdata);
                s_d.pb_snap = second_io_port_in[7:4];
            end else if (addr == dgp_pkg::OFS_PB_DIR) begin
                s_d.pb_dir = wdata;
            end else if (addr == dgp_pkg::OFS_OPTION) begin
                s_d.pullup_disable_n = wdata[dgp_pkg::OPT_PULLUP_DIS_N_BIT];
                s_d.ext_int_edge_select = wdata[dgp_pkg::OPT_EDGE_SEL_BIT];
            end else if (addr == dgp_pkg::OFS_INTCTL) begin
                s_d.pin_change_flag = wdata[dgp_pkg::INT_PIN_CHANGE_BIT];
                s_d.ext_int_flag = wdata[dgp_pkg::INT_EXT_FLAG_BIT];
            end
        end

        // hardware set wins over a software clear in the same cycle
        if (|pb_mism) begin
            s_d.pin_change_flag = 1'b1;
        end
        if (ext_hit) begin
            s_d.ext_int_flag = 1'b1;
        end
        s_d.wake = |pb_mism;

        // pin drivers; enabled peripherals take their pins over
        s_d.pa_out = s_d.pa_lat & dgp_pkg::PA_PUSH_PULL;
        s_d.pa_oe = ~s_d.pa_dir;
        s_d.pa_oe[dgp_pkg::PA_T0CK_BIT] = ~s_d.pa_dir[dgp_pkg::PA_T0CK_BIT]
                                          & ~s_d.pa_lat[dgp_pkg::PA_T0CK_BIT]
                                          & ~timer0_ext_enable;
        if (sync_serial_port_enable) begin
            s_d.pa_oe[dgp_pkg::PA_SS_BIT] = 1'b0;
        end
        s_d.pb_out = s_d.pb_lat;
        s_d.pb_oe = ~s_d.pb_dir;
        s_d.pb_pullup = s_d.pb_dir & {8{~s_d.pullup_disable_n}};
        s_d.t0ck = first_io_port_in[dgp_pkg::PA_T0CK_BIT];
        s_d.ss_n = first_io_port_in[dgp_pkg::PA_SS_BIT];
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_q <= dgp_pkg::STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata                 = s_q.rdata;
    assign first_io_port_out     = s_q.pa_out;
    assign first_io_port_oe      = s_q.pa_oe;
    assign second_io_port_out    = s_q.pb_out;
    assign second_io_port_oe     = s_q.pb_oe;
    assign second_port_pullup_en = s_q.pb_pullup;
    assign timer0_ext_clock_in   = s_q.t0ck;
    assign sync_serial_port_ss_n = s_q.ss_n;
    assign pin_change_flag       = s_q.pin_change_flag;
    assign ext_int_flag          = s_q.ext_int_flag;
    assign wake                  = s_q.wake;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_pa_dir_drive: assert property (wr && addr == dgp_pkg::OFS_PA_DIR && !timer0_ext_enable
        && !sync_serial_port_enable |=> first_io_port_oe[3:0] == ~$past(wdata[3:0]))
        else $error("first port enable does not follow direction write");
    a_pa_latch_out: assert property (wr && addr == dgp_pkg::OFS_PA_DATA
        |=> first_io_port_out[3:0] == $past(wdata[3:0]))
        else $error("first port latch not driven out");
    a_pb_read_pins: assert property (rd && addr == dgp_pkg::OFS_PB_DATA
        |=> rdata == $past(second_io_port_in))
        else $error("second port read is not pin level");
    a_pb_bit_mod: assert property (wr && addr == dgp_pkg::OFS_PB_BMOD
        |=> second_io_port_out[$past(wdata[2:0])] == $past(wdata[7]))
        else $error("bit modify did not set target bit");
    a_open_drain: assert property (first_io_port_out[dgp_pkg::PA_T0CK_BIT] == 1'b0
        && !(first_io_port_oe[dgp_pkg::PA_T0CK_BIT] && s_q.pa_lat[dgp_pkg::PA_T0CK_BIT]))
        else $error("timer clock pin drives high");
    a_ss_takeover: assert property (sync_serial_port_enable
        |=> !first_io_port_oe[dgp_pkg::PA_SS_BIT])
        else $error("slave select pin driven while serial port on");
    a_analog_zero: assert property (rd && addr == dgp_pkg::OFS_PA_DATA
        |=> (rdata[5:0] & $past(analog_mask(s_q.acfg))) == 6'h00)
        else $error("analog pin read nonzero");
    a_dir_reset: assert property ($rose(rstn) |-> s_q.pa_dir == dgp_pkg::PA_DIR_RST
        && s_q.acfg == dgp_pkg::ACFG_RST && second_port_pullup_en == 8'h00)
        else $error("reset values wrong");
    a_pullup_gate: assert property (##1 second_port_pullup_en
        == (~second_io_port_oe & {8{~s_q.pullup_disable_n}}))
        else $error("pull-up active on output pin");
    a_change_flag: assert property (|((second_io_port_in[7:4] ^ s_q.pb_snap) & s_q.pb_dir[7:4])
        |=> pin_change_flag && wake)
        else $error("pin change mismatch lost");
    a_snap_refresh: assert property (rd && addr == dgp_pkg::OFS_PB_DATA
        |=> s_q.pb_snap == $past(second_io_port_in[7:4]))
        else $error("snapshot not refreshed on read");
    a_ext_edge: assert property (s_q.ext_int_edge_select && s_q.edge_armed && !wr
        && $rose(second_io_port_in[dgp_pkg::PB_EXT_INT_BIT]) |=> ext_int_flag)
        else $error("rising edge interrupt missed");
    a_latch_any_dir: assert property (wr && addr == dgp_pkg::OFS_PB_DATA
        |=> s_q.pb_lat == $past(wdata))
        else $error("latch write dropped");
    a_pb_dir_drive: assert property (wr && addr == dgp_pkg::OFS_PB_DIR
        |=> second_io_port_oe == ~$past(wdata))
        else $error("second port enable does not follow direction write");
    a_t0_takeover: assert property (timer0_ext_enable
        |=> !first_io_port_oe[dgp_pkg::PA_T0CK_BIT])
        else $error("timer clock pin driven while timer uses it");
    a_snap_on_write: assert property (wr && addr == dgp_pkg::OFS_PB_DATA
        |=> s_q.pb_snap == $past(second_io_port_in[7:4]))
        else $error("snapshot not refreshed on write");
    a_acfg_write: assert property (wr && addr == dgp_pkg::OFS_ACFG
        |=> s_q.acfg == $past(wdata[2:0]))
        else $error("analog configuration write dropped");
    a_out_no_change: assert property (s_q.pb_dir[7:4] == 4'h0 && !pin_change_flag
        && !(wr && addr == dgp_pkg::OFS_INTCTL) |=> !pin_change_flag)
        else $error("output pins raised change flag");
    a_wake_clears: assert property (!(|((second_io_port_in[7:4] ^ s_q.pb_snap)
        & s_q.pb_dir[7:4])) |=> !wake)
        else $error("wake without mismatch");
    a_flag_sw_clear: assert property (wr && addr == dgp_pkg::OFS_INTCTL
        && !wdata[dgp_pkg::INT_PIN_CHANGE_BIT] && !(|pb_mism) |=> !pin_change_flag)
        else $error("change flag not cleared by software");

    c_pin_change: cover property (!pin_change_flag ##1 pin_change_flag);
    c_flag_clear: cover property (pin_change_flag ##1 !pin_change_flag);
    c_ext_fall: cover property (!s_q.ext_int_edge_select ##1 $rose(ext_int_flag));
    c_pullups_on: cover property (|second_port_pullup_en);
    c_pb_bit_mod: cover property (wr && addr == dgp_pkg::OFS_PB_BMOD);

endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench of the dual general-purpose port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin #1; total_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", nm, ex, got); end end
module tb_top;
    typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } dgp_row_s;
    logic       clock = 1'b0;
    logic       rstn  = 1'b0;
    logic [7:0] addr  = '0;
    logic [7:0] wdata = '0;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic       t0_en = 1'b0;
    logic       ss_en = 1'b0;
    logic [5:0] a_drv = 6'h3F;
    logic [5:0] a_en  = '1;
    logic [7:0] b_drv = '0;
    logic [7:0] b_en  = '1;
    logic [5:0] a_pin, a_out, a_oe;
    logic [7:0] b_pin, b_out, b_oe, b_pull, rdata;
    logic       t0ck, ss_n, pcf, eif, wake;
    int         n_errors     = 0;
    int         total_checks = 0;
    logic [5:0] amask [8] = '{6'h2F, 6'h0F, 6'h07, 6'h03, 6'h01, 6'h00, 6'h00, 6'h00};
    dgp_row_s   rows [6] = '{
        '{dgp_pkg::OFS_PA_DIR, 8'hFF, 8'h3F},
        '{dgp_pkg::OFS_PA_DIR, 8'h15, 8'h15},
        '{dgp_pkg::OFS_ACFG,   8'hFF, 8'h07},
        '{dgp_pkg::OFS_OPTION, 8'hFF, 8'hC0},
        '{dgp_pkg::OFS_PB_DIR, 8'h5A, 8'h5A},
        '{8'h10,               8'hFF, 8'h00}};
    always #5 clock = ~clock;
    dgp_port dut_u (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .first_io_port_in(a_pin), .first_io_port_out(a_out),
        .first_io_port_oe(a_oe), .second_io_port_in(b_pin), .second_io_port_out(b_out),
        .second_io_port_oe(b_oe), .second_port_pullup_en(b_pull), .timer0_ext_enable(t0_en),
        .sync_serial_port_enable(ss_en), .timer0_ext_clock_in(t0ck),
        .sync_serial_port_ss_n(ss_n), .pin_change_flag(pcf), .ext_int_flag(eif), .wake(wake));
    dgp_board brd_u (.clock(clock), .a_out(a_out), .a_oe(a_oe), .a_drv(a_drv), .a_en(a_en),
        .b_out(b_out), .b_oe(b_oe), .b_pull(b_pull), .b_drv(b_drv), .b_en(b_en),
        .a_pin(a_pin), .b_pin(b_pin));
    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        `CHK(nm, e, rdata)
        idle(1);
    endtask
    initial begin
        idle(4);
        `CHK("oe_rst", 8'h00, b_oe)
        rstn <= 1'b1;
        idle(2);
        `CHK("pa_oe", 6'h00, a_oe)
        `CHK("pull_rst", 8'h00, b_pull)
        rd_chk("opt_rst", dgp_pkg::OFS_OPTION, 8'hC0);
        rd_chk("acfg_rst", dgp_pkg::OFS_ACFG, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_chk("reg", rows[i].a, rows[i].e);
        end
        wr_reg(dgp_pkg::OFS_PA_DIR, 8'h3F);
        // all pins set as inputs; analog pins read back as zero for each of the 8 configuration codes
        for (int c = 0; c < 8; c++) begin
            wr_reg(dgp_pkg::OFS_ACFG, 8'(c));
            rd_chk("analog", dgp_pkg::OFS_PA_DATA, {2'b00, 6'h3F & ~amask[c]});
        end
        a_drv <= 6'h15;
        wr_reg(dgp_pkg::OFS_PA_DATA, 8'h00);
        rd_chk("pins", dgp_pkg::OFS_PA_DATA, 8'h15);
        wr_reg(dgp_pkg::OFS_PA_BMOD, 8'h81);
        wr_reg(dgp_pkg::OFS_PA_DIR, 8'h00);
        idle(2);
        `CHK("rmw_out", 6'h07, a_out)
        `CHK("od_oe", 6'h2F, a_oe)
        wr_reg(dgp_pkg::OFS_PA_DIR, 8'h3F);
        wr_reg(dgp_pkg::OFS_PA_DATA, 8'h0A);
        wr_reg(dgp_pkg::OFS_PA_DIR, 8'h00);
        idle(2);
        `CHK("lat_out", 6'h0A, a_out)
        `CHK("lat_oe", 6'h3F, a_oe)
        t0_en <= 1'b1;
        ss_en <= 1'b1;
        idle(2);
        `CHK("periph_oe", 6'h0F, a_oe)
        wr_reg(dgp_pkg::OFS_PA_DIR, 8'h3F);
        a_drv <= 6'h10;
        idle(3);
        `CHK("t0ck", 1'b1, t0ck)
        `CHK("ss_n", 1'b0, ss_n)
        wr_reg(dgp_pkg::OFS_PB_DIR, 8'h0F);
        wr_reg(dgp_pkg::OFS_OPTION, 8'h00);
        wr_reg(dgp_pkg::OFS_PB_DATA, 8'hA5);
        b_en <= 8'h00;
        idle(2);
        `CHK("pb_oe", 8'hF0, b_oe)
        `CHK("pb_out", 8'hA5, b_out)
        `CHK("pull_on", 8'h0F, b_pull)
        rd_chk("pb_pull", dgp_pkg::OFS_PB_DATA, 8'hAF);
        wr_reg(dgp_pkg::OFS_OPTION, 8'h80);
        b_en <= 8'hFF;
        idle(2);
        `CHK("pull_off", 8'h00, b_pull)
        wr_reg(dgp_pkg::OFS_PB_DIR, 8'hFF);
        rd_chk("pb_snap", dgp_pkg::OFS_PB_DATA, 8'h00);
        wr_reg(dgp_pkg::OFS_INTCTL, 8'h00);
        b_drv <= 8'h0F;
        idle(3);
        `CHK("low_chg", 1'b0, pcf)
        `CHK("rise_off", 1'b0, eif)
        // no polling of the second port while waiting for a change
        b_drv <= 8'h8F;
        for (int i = 0; i < 8 && pcf !== 1'b1; i++) idle(1);
        if (pcf !== 1'b1) begin
            n_errors++;
        end
        `CHK("wake", 1'b1, wake)
        wr_reg(dgp_pkg::OFS_INTCTL, 8'h00);
        idle(2);
        `CHK("persist", 1'b1, pcf)
        rd_chk("pb_rd", dgp_pkg::OFS_PB_DATA, 8'h8F);
        wr_reg(dgp_pkg::OFS_INTCTL, 8'h00);
        idle(2);
        `CHK("cleared", 1'b0, pcf)
        `CHK("wake_off", 1'b0, wake)
        wr_reg(dgp_pkg::OFS_PB_DATA, 8'h25);
        wr_reg(dgp_pkg::OFS_PB_DIR, 8'h7F);
        idle(3);
        `CHK("out_excl", 1'b0, pcf)
        b_drv <= 8'h8E;
        idle(3);
        `CHK("fall", 1'b1, eif)
        wr_reg(dgp_pkg::OFS_INTCTL, 8'h00);
        wr_reg(dgp_pkg::OFS_OPTION, 8'hC0);
        b_drv <= 8'h8F;
        idle(3);
        rd_chk("rise", dgp_pkg::OFS_INTCTL, 8'h02);
        wr_reg(dgp_pkg::OFS_PB_BMOD, 8'h86);
        idle(2);
        `CHK("pb_rmw", 8'h4F, b_out)
        wr_reg(dgp_pkg::OFS_OPTION, 8'h00);
        idle(2);
        `CHK("pull_on2", 8'h7F, b_pull)
        // second reset in mid-run, pin 0 held high throughout
        rstn <= 1'b0;
        idle(2);
        rstn <= 1'b1;
        idle(2);
        `CHK("pull_rst2", 8'h00, b_pull)
        `CHK("eif_rst2", 1'b0, eif)
        rd_chk("dir_rst2", dgp_pkg::OFS_PA_DIR, 8'h3F);
        print_verdict();
    end
endmodule
`default_nettype wire
